// ==== core/ssr_defs.svh ====
// Purpose: offsets, fields, reset values and timing counts of the supply supervisor
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH
// register byte offsets
`define SSR_OFS_CTRL 8'h00
`define SSR_OFS_STATUS 8'h04
`define SSR_OFS_IRQ_STAT 8'h08
`define SSR_OFS_IRQ_CLR 8'h0c
`define SSR_OFS_IRQ_EN 8'h10
// control fields
`define SSR_CTRL_SLD_EN 0
`define SSR_CTRL_LVL_LSB 1
`define SSR_CTRL_LVL_MSB 3
`define SSR_CTRL_FALL_SEL 4
`define SSR_CTRL_RISE_SEL 5
`define SSR_CTRL_VREF_AUTO 6
// status fields
`define SSR_ST_SLD_BELOW 0
`define SSR_ST_BOR_LSB 1
`define SSR_ST_BOR_MSB 3
`define SSR_ST_BOR_OFF 4
`define SSR_ST_CORE_RUN 5
// interrupt bits
`define SSR_IRQ_FALL 0
`define SSR_IRQ_RISE 1
// reset values
`define SSR_CTRL_RST 7'h00
`define SSR_IRQ_EN_RST 2'h0
`define SSR_BOR_LVL_RST 3'h0
// widths and counts
`define SSR_BOR_LEVELS 5
`define SSR_SLD_LEVELS 7
`define SSR_TMR_W 19
`define SSR_CLK_MHZ 100
`define SSR_STARTUP_BOR_US 3300
`define SSR_STARTUP_NOBOR_US 1000
`define SSR_STARTUP_BOR_CYC (`SSR_STARTUP_BOR_US * `SSR_CLK_MHZ)
`define SSR_STARTUP_NOBOR_CYC (`SSR_STARTUP_NOBOR_US * `SSR_CLK_MHZ)
`endif

// ==== core/ssr_pkg.sv ====
// Purpose: types of the supply supervisor
// Assumes: nothing
// Notes: states are one-hot
package ssr_pkg;
    typedef enum logic [3:0] {
        SSR_HOLD = 4'b0001,
        SSR_LOAD = 4'b0010,
        SSR_START = 4'b0100,
        SSR_RUN = 4'b1000
    } ssr_state_t;
    typedef enum logic [2:0] {
        SSR_PM_RUN = 3'h0,
        SSR_PM_SLEEP = 3'h1,
        SSR_PM_LPRUN = 3'h2,
        SSR_PM_LPSLEEP = 3'h3,
        SSR_PM_STOP = 3'h4,
        SSR_PM_STANDBY = 3'h5
    } ssr_pmode_t;
endpackage

// ==== core/ssr_startup_timer.sv ====
// Purpose: one-shot start-up delay counter
// Assumes: start is a one-cycle pulse, len at least 1
// Notes: done pulses once, len cycles after start
`timescale 1ns/10ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_startup_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [`SSR_TMR_W-1:0] len,
    output logic done
);
    logic [`SSR_TMR_W-1:0] cnt_q;
    logic busy_q;
    // countdown, restart on start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= len - `SSR_TMR_W'(1);
                busy_q <= 1'b1;
            end else if (abort) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - `SSR_TMR_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/ssr_supervisor.sv ====
// Purpose: supply supervision, reset sequencing, level detector and regulator select
// Assumes: comparator and option inputs synchronous to CLK
// Notes: registers over AXI4-Lite; one level interrupt
// Overview of operation
// - Core reset stays asserted while the supply is below the power-on or brownout level.
// - Reaching the power-on level starts an option load that confirms, moves or disables brownout.
// - Five brownout levels are selectable through the loaded options.
// - Once disabled by options, brownout stays off until the next hold reloads it from BOR_AT_POWERUP; until then only power-on/down governs reset.
// - A control register bit turns the internal voltage reference off automatically in Stop mode.
// - Start-up lasts 3.3 ms with brownout active at power-up, else 1 ms.
// - The level detector compares the supply against one of seven software levels.
// - The detector can interrupt on falling below, rising above, or both.
// - Run mode selects the main regulator.
// - Low-power run, low-power sleep and Stop select the low-power regulator.
// - Standby powers the regulator down, output high impedance, core unpowered.
// - Standby entry loses core state; only the standby domain keeps its contents.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_supervisor #(
    parameter int unsigned STARTUP_BOR_CYC = `SSR_STARTUP_BOR_CYC,
    parameter int unsigned STARTUP_NOBOR_CYC = `SSR_STARTUP_NOBOR_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // analog comparators, high while supply is above the level
    input wire logic VDD_ABOVE_POR,
    input wire logic [`SSR_BOR_LEVELS-1:0] BOR_CMP,
    input wire logic [`SSR_SLD_LEVELS-1:0] SLD_CMP,
    input wire logic BOR_AT_POWERUP,
    // option loader
    output logic OPT_LOAD_REQ,
    input wire logic OPT_LOAD_DONE,
    input wire logic [2:0] OPT_BOR_LEVEL,
    // power mode and regulator
    input wire ssr_pkg::ssr_pmode_t PWR_MODE,
    output logic REG_MAIN,
    output logic REG_LOWPWR,
    output logic REG_OFF,
    output logic CORE_PWR_EN,
    output logic VREF_EN,
    output logic CORE_RST_N,
    output logic IRQ,
    // axi4-lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    import ssr_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;
    ssr_state_t state_q;
    logic bor_strap_q, bor_off_q;
    logic [2:0] bor_lvl_q;
    logic [6:0] ctrl_q;
    logic [1:0] irq_stat_q, irq_en_q;
    logic sld_armed_q, sld_below_q;
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr, standby, supply_ok, bor_ok, sld_below, fall_ev, rise_ev;
    logic tmr_start, tmr_done;
    logic [`SSR_TMR_W-1:0] tmr_len;

    // picks one comparator bit, clamping the index
    function automatic logic pick(input logic [6:0] cmp, input logic [2:0] idx,
                                  input logic [2:0] top);
        pick = (idx > top) ? cmp[top] : cmp[idx];
    endfunction

    // reset release through two flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign standby = (PWR_MODE == SSR_PM_STANDBY);
    assign bor_ok = pick({2'b00, BOR_CMP}, bor_lvl_q, 3'(`SSR_BOR_LEVELS - 1));
    assign supply_ok = VDD_ABOVE_POR && (bor_off_q || bor_ok);
    assign tmr_len = bor_strap_q ? `SSR_TMR_W'(STARTUP_BOR_CYC) : `SSR_TMR_W'(STARTUP_NOBOR_CYC);
    assign tmr_start = (state_q == SSR_LOAD) && supply_ok && OPT_LOAD_DONE;

    // reset sequencer
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SSR_HOLD;
        end else begin
            case (state_q)
                SSR_HOLD: state_q <= (VDD_ABOVE_POR && !standby) ? SSR_LOAD : SSR_HOLD;
                SSR_LOAD: begin
                    if (!supply_ok || standby) begin
                        state_q <= SSR_HOLD;
                    end else if (OPT_LOAD_DONE) begin
                        state_q <= SSR_START;
                    end
                end
                SSR_START: begin
                    if (!supply_ok || standby) begin
                        state_q <= SSR_HOLD;
                    end else if (tmr_done) begin
                        state_q <= SSR_RUN;
                    end
                end
                SSR_RUN: state_q <= (!supply_ok || standby) ? SSR_HOLD : SSR_RUN;
                default: state_q <= SSR_HOLD;
            endcase
        end
    end

    ssr_startup_timer u_timer (
        .clk(CLK),
        .rst_n(rst_n),
        .start(tmr_start),
        .abort(state_q != SSR_START),
        .len(tmr_len),
        .done(tmr_done)
    );

    // brownout options, strap caught while held
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bor_strap_q <= 1'b0;
            bor_off_q <= 1'b1;
            bor_lvl_q <= `SSR_BOR_LVL_RST;
        end else if (state_q == SSR_HOLD) begin
            bor_strap_q <= BOR_AT_POWERUP;
            bor_off_q <= !BOR_AT_POWERUP;
            bor_lvl_q <= `SSR_BOR_LVL_RST;
        end else if (tmr_start) begin
            bor_off_q <= (OPT_BOR_LEVEL >= 3'(`SSR_BOR_LEVELS));
            bor_lvl_q <= OPT_BOR_LEVEL;
        end
    end

    assign CORE_RST_N = (state_q == SSR_RUN);
    assign OPT_LOAD_REQ = (state_q == SSR_LOAD);

    // main regulator in run and sleep
    always_comb begin
        REG_MAIN = (PWR_MODE == SSR_PM_RUN) || (PWR_MODE == SSR_PM_SLEEP);
        REG_LOWPWR = (PWR_MODE == SSR_PM_LPRUN) || (PWR_MODE == SSR_PM_LPSLEEP) ||
                     (PWR_MODE == SSR_PM_STOP);
        REG_OFF = standby;
        CORE_PWR_EN = !standby;
        VREF_EN = !standby && !((PWR_MODE == SSR_PM_STOP) && ctrl_q[`SSR_CTRL_VREF_AUTO]);
    end

    assign sld_below = !pick(SLD_CMP, ctrl_q[`SSR_CTRL_LVL_MSB:`SSR_CTRL_LVL_LSB],
                             3'(`SSR_SLD_LEVELS - 1));
    assign fall_ev = sld_armed_q && sld_below && !sld_below_q;
    assign rise_ev = sld_armed_q && !sld_below && sld_below_q;

    // detector history, armed one cycle after enable
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sld_armed_q <= 1'b0;
            sld_below_q <= 1'b0;
        end else begin
            sld_armed_q <= ctrl_q[`SSR_CTRL_SLD_EN] && !standby;
            sld_below_q <= sld_below;
        end
    end

    // write channel capture and commit
    assign AWREADY = !aw_got_q && !BVALID;
    assign WREADY = !w_got_q && !BVALID;
    assign do_wr = aw_got_q && w_got_q && !BVALID;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            BVALID <= 1'b0;
            BRESP <= 2'b00;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_got_q <= 1'b1;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_q <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (awaddr_q > `SSR_OFS_IRQ_EN || awaddr_q[1:0] != 2'b00) ? 2'b11 : 2'b00;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // control and enable registers, cleared in standby
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SSR_CTRL_RST;
            irq_en_q <= `SSR_IRQ_EN_RST;
        end else if (standby) begin
            ctrl_q <= `SSR_CTRL_RST;
            irq_en_q <= `SSR_IRQ_EN_RST;
        end else if (do_wr && wstrb_q[0]) begin
            if (awaddr_q == `SSR_OFS_CTRL) begin
                ctrl_q <= wdata_q[6:0];
            end
            if (awaddr_q == `SSR_OFS_IRQ_EN) begin
                irq_en_q <= wdata_q[1:0];
            end
        end
    end

    // sticky detector events, set beats clear
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 2'b00;
        end else if (standby) begin
            irq_stat_q <= 2'b00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((do_wr && wstrb_q[0] &&
                          awaddr_q == `SSR_OFS_IRQ_CLR) ? wdata_q[1:0] : 2'b00))
                          | {rise_ev && ctrl_q[`SSR_CTRL_RISE_SEL],
                             fall_ev && ctrl_q[`SSR_CTRL_FALL_SEL]};
        end
    end
    assign IRQ = |(irq_stat_q & irq_en_q);

    // read channel, one cycle answer
    assign ARREADY = !RVALID;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= 2'b00;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= 2'b00;
            RDATA <= '0;
            case (ARADDR)
                `SSR_OFS_CTRL: RDATA <= {25'h0, ctrl_q};
                `SSR_OFS_STATUS: RDATA <= {26'h0, CORE_RST_N, bor_off_q, bor_lvl_q,
                                           sld_armed_q && sld_below};
                `SSR_OFS_IRQ_STAT: RDATA <= {30'h0, irq_stat_q};
                `SSR_OFS_IRQ_CLR: RDATA <= '0;
                `SSR_OFS_IRQ_EN: RDATA <= {30'h0, irq_en_q};
                default: RRESP <= 2'b11;
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // checks
    sequence s_fall_seen;
        fall_ev && ctrl_q[`SSR_CTRL_FALL_SEL] && !standby;
    endsequence
    sequence s_rise_seen;
        rise_ev && ctrl_q[`SSR_CTRL_RISE_SEL] && !standby;
    endsequence
    sequence s_load_done;
        (state_q == SSR_LOAD) && supply_ok && !standby && OPT_LOAD_DONE;
    endsequence

    AST_HOLD_LOW_POR: assert property (@(posedge CLK) disable iff (!rst_n)
        !VDD_ABOVE_POR |=> !CORE_RST_N)
        else $error("core released with supply below power-on level");
    AST_HOLD_LOW_BOR: assert property (@(posedge CLK) disable iff (!rst_n)
        (!bor_off_q && !bor_ok && state_q != SSR_HOLD) |=> (state_q == SSR_HOLD) && !CORE_RST_N)
        else $error("core released with supply below brownout level");
    AST_LOAD_AFTER_POR: assert property (@(posedge CLK) disable iff (!rst_n)
        (state_q == SSR_HOLD && VDD_ABOVE_POR && !standby) |=> OPT_LOAD_REQ)
        else $error("option load not requested at power-on level");
    AST_BOR_LEVEL_LOADED: assert property (@(posedge CLK) disable iff (!rst_n)
        s_load_done |=> bor_lvl_q == $past(OPT_BOR_LEVEL)
                        && bor_off_q == ($past(OPT_BOR_LEVEL) > 3'd4))
        else $error("brownout option not taken");
    AST_BOR_STAYS_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        (bor_off_q && state_q == SSR_RUN) |=> bor_off_q)
        else $error("brownout came back after disable");
    AST_VREF_STOP: assert property (@(posedge CLK) disable iff (!rst_n)
        (PWR_MODE == SSR_PM_STOP && ctrl_q[`SSR_CTRL_VREF_AUTO]) |-> !VREF_EN)
        else $error("reference left on in stop");
    AST_STARTUP_WAIT: assert property (@(posedge CLK) disable iff (!rst_n)
        s_load_done |=> (!CORE_RST_N [*8]) ##0 (state_q == SSR_START || state_q == SSR_HOLD))
        else $error("start-up delay skipped");
    AST_SLD_QUIET: assert property (@(posedge CLK) disable iff (!rst_n)
        !ctrl_q[`SSR_CTRL_SLD_EN] ##1 !ctrl_q[`SSR_CTRL_SLD_EN] |-> !fall_ev && !rise_ev)
        else $error("detector event while disabled");
    AST_SLD_FALL: assert property (@(posedge CLK) disable iff (!rst_n)
        s_fall_seen |=> irq_stat_q[`SSR_IRQ_FALL])
        else $error("falling crossing not flagged");
    AST_SLD_RISE: assert property (@(posedge CLK) disable iff (!rst_n)
        s_rise_seen |=> irq_stat_q[`SSR_IRQ_RISE] ##0 (IRQ || !irq_en_q[`SSR_IRQ_RISE]))
        else $error("rising crossing not flagged");
    AST_MAIN_REG: assert property (@(posedge CLK) disable iff (!rst_n)
        PWR_MODE == SSR_PM_RUN |-> REG_MAIN && !REG_LOWPWR && !REG_OFF)
        else $error("run without main regulator");
    AST_LP_REG: assert property (@(posedge CLK) disable iff (!rst_n)
        (PWR_MODE inside {SSR_PM_LPRUN, SSR_PM_LPSLEEP, SSR_PM_STOP}) |-> REG_LOWPWR && !REG_MAIN)
        else $error("low-power mode without low-power regulator");
    AST_STANDBY_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
        standby |-> REG_OFF && !CORE_PWR_EN ##1 !CORE_RST_N && ctrl_q == `SSR_CTRL_RST)
        else $error("standby left core powered or state kept");
endmodule
`default_nettype wire

// ==== bench/ssr_far_model.sv ====
// Purpose: supply comparators and option store facing the supervisor
// Assumes: supply level given by the bench in millivolts
// Notes: option level lines toggle every cycle while no load is answered
`timescale 1ns/10ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_far_model #(
    parameter int POR_MV = 1650,
    parameter int BOR_LO_MV = 1800,
    parameter int BOR_STEP_MV = 300,
    parameter int SLD_LO_MV = 1850,
    parameter int SLD_STEP_MV = 200
) (
    // clock
    input wire logic clk,
    // bench controls
    input wire logic [15:0] supply_mv,
    input wire logic [2:0] opt_code,
    input wire logic [7:0] load_delay,
    // comparators
    output logic vdd_above_por,
    output logic [`SSR_BOR_LEVELS-1:0] bor_cmp,
    output logic [`SSR_SLD_LEVELS-1:0] sld_cmp,
    // option store
    input wire logic opt_load_req,
    output logic opt_load_done,
    output logic [2:0] opt_bor_level
);
    logic [7:0] wait_q;
    // comparators, high while the supply is above each level
    always_comb begin
        vdd_above_por = int'(supply_mv) > POR_MV;
        for (int i = 0; i < `SSR_BOR_LEVELS; i++) begin
            bor_cmp[i] = int'(supply_mv) > BOR_LO_MV + i * BOR_STEP_MV;
        end
        for (int i = 0; i < `SSR_SLD_LEVELS; i++) begin
            sld_cmp[i] = int'(supply_mv) > SLD_LO_MV + i * SLD_STEP_MV;
        end
    end
    // start values before the first edge
    initial begin
        opt_load_done = 1'b0;
        opt_bor_level = 3'h0;
        wait_q = 8'h00;
    end
    // one-cycle answer after load_delay cycles, else a moving pattern
    always @(posedge clk) begin
        if (opt_load_req && !opt_load_done && wait_q == load_delay) begin
            opt_load_done <= 1'b1;
            opt_bor_level <= opt_code;
        end else begin
            opt_load_done <= 1'b0;
            opt_bor_level <= ~opt_bor_level;
        end
        wait_q <= (opt_load_req && !opt_load_done) ? wait_q + 8'h01 : 8'h00;
    end
endmodule
`default_nettype wire

// ==== bench/tb_ssr_supervisor.sv ====
// Purpose: self-checking bench of the supply supervisor
// Assumes: short start-up counts of 20 and 10 cycles
// Notes: register reads are checked by a monitor against a queue
`timescale 1ns/10ps
`default_nettype none
`include "ssr_defs.svh"
module tb_ssr_supervisor;
    import ssr_pkg::*;
    localparam logic [7:0] A_CTL = `SSR_OFS_CTRL;
    localparam logic [7:0] A_ST = `SSR_OFS_STATUS;
    localparam logic [7:0] A_IS = `SSR_OFS_IRQ_STAT;
    localparam logic [7:0] A_IC = `SSR_OFS_IRQ_CLR;
    localparam logic [7:0] A_IE = `SSR_OFS_IRQ_EN;
    logic CLK, ARST_N, VDD_ABOVE_POR, BOR_AT_POWERUP, OPT_LOAD_REQ, OPT_LOAD_DONE;
    logic [4:0] BOR_CMP;
    logic [6:0] SLD_CMP;
    logic [2:0] OPT_BOR_LEVEL, opt_code;
    ssr_pmode_t PWR_MODE;
    logic REG_MAIN, REG_LOWPWR, REG_OFF, CORE_PWR_EN, VREF_EN, CORE_RST_N, IRQ;
    logic [7:0] AWADDR, ARADDR, load_delay;
    logic [31:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY;
    logic [15:0] supply_mv;
    logic [65:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [65:0] rx;
    int bad_count = 0;
    int tests_run = 0;
    int lvl, mv;

    ssr_supervisor #(.STARTUP_BOR_CYC(20), .STARTUP_NOBOR_CYC(10)) u_dut (
        .CLK(CLK), .ARST_N(ARST_N), .VDD_ABOVE_POR(VDD_ABOVE_POR), .BOR_CMP(BOR_CMP),
        .SLD_CMP(SLD_CMP), .BOR_AT_POWERUP(BOR_AT_POWERUP), .OPT_LOAD_REQ(OPT_LOAD_REQ),
        .OPT_LOAD_DONE(OPT_LOAD_DONE), .OPT_BOR_LEVEL(OPT_BOR_LEVEL), .PWR_MODE(PWR_MODE),
        .REG_MAIN(REG_MAIN), .REG_LOWPWR(REG_LOWPWR), .REG_OFF(REG_OFF),
        .CORE_PWR_EN(CORE_PWR_EN), .VREF_EN(VREF_EN), .CORE_RST_N(CORE_RST_N), .IRQ(IRQ),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
    );
    ssr_far_model u_far (
        .clk(CLK), .supply_mv(supply_mv), .opt_code(opt_code), .load_delay(load_delay),
        .vdd_above_por(VDD_ABOVE_POR), .bor_cmp(BOR_CMP), .sld_cmp(SLD_CMP),
        .opt_load_req(OPT_LOAD_REQ), .opt_load_done(OPT_LOAD_DONE),
        .opt_bor_level(OPT_BOR_LEVEL)
    );

    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic sup(input int v);
        @(posedge CLK);
        supply_mv <= 16'(v);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        wr_q.push_back(r);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        rd_q.push_back({r, m, d});
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        RREADY <= 1'b0;
    endtask
    // wait for the option answer, then time the reset release
    task automatic power_up(input int len);
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (OPT_LOAD_DONE !== 1'b1 && n < 500);
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (CORE_RST_N !== 1'b1 && n < 500);
        chk(34'(n), 34'(len + 2));
    endtask

    // monitor takes the oldest expected answer at each handshake
    always @(posedge CLK) begin
        if (RVALID && RREADY && rd_q.size() > 0) begin
            rx = rd_q.pop_front();
            chk({RRESP, RDATA & rx[63:32]}, {rx[65:64], rx[31:0] & rx[63:32]});
        end
        if (BVALID && BREADY && wr_q.size() > 0) chk(34'(BRESP), 34'(wr_q.pop_front()));
    end
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        ARST_N = 1'b0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
        AWADDR = 8'h00;
        ARADDR = 8'h00;
        WDATA = 32'h0;
        WSTRB = 4'hf;
        PWR_MODE = SSR_PM_RUN;
        BOR_AT_POWERUP = 1'b1;
        opt_code = 3'h2;
        load_delay = 8'h07;
        supply_mv = 16'd3300;
        rx = $urandom(32'hf692);
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        cyc(3);
        chk(34'({OPT_LOAD_REQ, CORE_RST_N}), 34'h2);
        power_up(20);
        rd(A_ST, 32'h24, 32'h3e, 2'b00);
        rd(A_CTL, 32'h0, 32'hffffffff, 2'b00);
        rd(A_IE, 32'h0, 32'hffffffff, 2'b00);
        // brownout fall, then reload that disables brownout
        @(posedge CLK);
        supply_mv <= 16'd2300;
        BOR_AT_POWERUP <= 1'b0;
        opt_code <= 3'h5;
        load_delay <= 8'h00;
        cyc(2);
        chk(34'(CORE_RST_N), 34'h0);
        power_up(10);
        rd(A_ST, 32'h30, 32'h30, 2'b00);
        sup(1700);
        cyc(3);
        chk(34'(CORE_RST_N), 34'h1);
        // detector in fall, rise and both modes
        sup(3300);
        wr(A_IE, 32'h3, 2'b00);
        for (int s = 1; s < 4; s++) begin
            wr(A_CTL, 32'(5 + 16 * s), 2'b00);
            wr(A_IC, 32'h3, 2'b00);
            cyc(2);
            sup(2200);
            cyc(2);
            chk(34'(IRQ), 34'(s % 2));
            sup(2400);
            cyc(2);
            rd(A_IS, 32'(s), 32'h3, 2'b00);
            chk(34'(IRQ), 34'h1);
        end
        wr(A_IE, 32'h0, 2'b00);
        wr(A_IC, 32'h3, 2'b00);
        sup(2200);
        cyc(2);
        chk(34'(IRQ), 34'h0);
        rd(A_ST, 32'h1, 32'h1, 2'b00);
        wr(A_IE, 32'h3, 2'b00);
        cyc(1);
        chk(34'(IRQ), 34'h1);
        wr(A_CTL, 32'h34, 2'b00);
        wr(A_IC, 32'h3, 2'b00);
        sup(2400);
        cyc(2);
        rd(A_IS, 32'h0, 32'h3, 2'b00);
        sup(2200);
        cyc(2);
        rd(A_ST, 32'h0, 32'h1, 2'b00);
        chk(34'(IRQ), 34'h0);
        // random levels and supplies against the below flag
        for (int i = 0; i < 8; i++) begin
            lvl = $urandom_range(6, 0);
            mv = $urandom_range(3400, 1700);
            wr(A_CTL, 32'(1 + 2 * lvl), 2'b00);
            sup(mv);
            cyc(2);
            rd(A_ST, 32'(mv <= 1850 + 200 * lvl), 32'h1, 2'b00);
        end
        // regulator per power mode with reference auto-off
        wr(A_CTL, 32'h40, 2'b00);
        for (int m = 0; m < 5; m++) begin
            @(posedge CLK);
            PWR_MODE <= ssr_pmode_t'(3'(m));
            cyc(1);
            chk(34'({REG_MAIN, REG_LOWPWR, REG_OFF, CORE_PWR_EN, VREF_EN}),
                34'({m < 2, m > 1, 2'b01, m != 4}));
        end
        wr(A_IE, 32'h3, 2'b00);
        @(posedge CLK);
        PWR_MODE <= SSR_PM_STANDBY;
        cyc(2);
        chk(34'({REG_MAIN, REG_LOWPWR, REG_OFF, CORE_PWR_EN, VREF_EN, CORE_RST_N}),
            34'h08);
        @(posedge CLK);
        PWR_MODE <= SSR_PM_RUN;
        BOR_AT_POWERUP <= 1'b1;
        opt_code <= 3'h0;
        load_delay <= 8'h03;
        supply_mv <= 16'd3300;
        power_up(20);
        rd(A_CTL, 32'h0, 32'hffffffff, 2'b00);
        rd(A_IE, 32'h0, 32'hffffffff, 2'b00);
        rd(A_IC, 32'h0, 32'hffffffff, 2'b00);
        rd(8'h14, 32'h0, 32'hffffffff, 2'b11);
        wr(8'h20, 32'h1, 2'b11);
        cyc(2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
